/* design/gpd_pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module gpd_pin_sync (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [gpd_pkg::SYNC_W-1:0] raw,
    output logic      [gpd_pkg::SYNC_W-1:0] level
);

    logic [gpd_pkg::SYNC_W-1:0] stage1;
    logic [gpd_pkg::SYNC_W-1:0] stage2;
    logic [gpd_pkg::SYNC_W-1:0] stage3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= gpd_pkg::RST_SYNC;
            stage2 <= gpd_pkg::RST_SYNC;
            stage3 <= gpd_pkg::RST_SYNC;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // The filter looks only at stages two and three, never the metastable first one.
    genvar i;
    generate
        for (i = 0; i < gpd_pkg::SYNC_W; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    level[i] <= 1'b0;
                end else if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    endgenerate

endmodule

/* design/gpd_pkg.sv */
// Shared constants for the dual general-purpose port block.
package gpd_pkg;

    // Bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Port widths.
    localparam int P7_W   = 3;
    localparam int P8_W   = 4;
    localparam int SYNC_W = P7_W + P8_W + 1;

    // Byte offsets of the registers.
    localparam logic [7:0] OFS_P7_DATA = 8'h00;
    localparam logic [7:0] OFS_P7_DIR  = 8'h04;
    localparam logic [7:0] OFS_P7_PULL = 8'h08;
    localparam logic [7:0] OFS_P8_DATA = 8'h0C;
    localparam logic [7:0] OFS_P8_DIR  = 8'h10;
    localparam logic [7:0] OFS_P8_PULL = 8'h14;
    localparam logic [7:0] OFS_CTRL    = 8'h18;
    localparam logic [7:0] OFS_P7_RMW  = 8'h1C;
    localparam logic [7:0] OFS_P8_RMW  = 8'h20;

    // Control register fields.
    localparam int CTRL_PIN_FLOAT = 0;
    localparam int CTRL_TRIG_ALT  = 1;
    localparam int CTRL_W         = 2;

    // Positions inside the synchroniser vector.
    localparam int SYN_P7_LSB  = 0;
    localparam int SYN_P8_LSB  = P7_W;
    localparam int SYN_ALT_BIT = P7_W + P8_W;

    // Pin positions of the shared functions.
    localparam int PIN_TMR_OUT  = 0;
    localparam int PIN_TMR_IN   = 1;
    localparam int PIN_TRIG_IN  = 3;

    // Values after reset.
    localparam logic [P7_W-1:0]   RST_P7     = 3'h0;
    localparam logic [P8_W-1:0]   RST_P8     = 4'h0;
    localparam logic [CTRL_W-1:0] RST_CTRL   = 2'h0;
    localparam logic [SYNC_W-1:0] RST_SYNC   = 8'h00;

    // Bus answers.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* design/gpd_port_top.sv */
// Two general-purpose ports (three and four pins) behind an AXI4-Lite register slave.
// Functional notes
// - Direction bit one makes pin an output
// - Direction bit zero makes pin an input
// - Output pin drives latch; writes reach pin
// - Latch always written; input pins not driven
// - Data read returns latch for outputs
// - Data read returns pin level for inputs
// - Read-modify-write read returns latch always
// - Peripheral output enable replaces latch on pin
// - Peripheral-driven pin reads back actual level
// - Peripheral inputs need direction zero; read level
// - Reset clears all direction bits
// - Pin-float in stop/watch forces high impedance
// - Floated pins gate input to low
// - Port eight pin three keeps input if enabled
// - Pin-float clear keeps pins unchanged in standby
// - Pull-up bit one connects pull-up resistor
// - Pin driving low disconnects its pull-up
// - Three-pin port uses bits two to zero
// - Four-pin port uses bits three to zero
// - Trigger inputs routable to alternate pin
`timescale 1ns/1ps
module gpd_port_top (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [gpd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [gpd_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic      [1:0]                 s_axi_bresp,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [gpd_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic      [gpd_pkg::DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]                 s_axi_rresp,
    input  wire logic [gpd_pkg::P7_W-1:0]   p7_pin_in,
    output logic      [gpd_pkg::P7_W-1:0]   p7_pin_out,
    output logic      [gpd_pkg::P7_W-1:0]   p7_pin_oe,
    output logic      [gpd_pkg::P7_W-1:0]   p7_pullup_on,
    input  wire logic [gpd_pkg::P8_W-1:0]   p8_pin_in,
    output logic      [gpd_pkg::P8_W-1:0]   p8_pin_out,
    output logic      [gpd_pkg::P8_W-1:0]   p8_pin_oe,
    output logic      [gpd_pkg::P8_W-1:0]   p8_pullup_on,
    input  wire logic                       alternate_trigger_pin,
    input  wire logic                       stop_mode,
    input  wire logic                       watch_mode,
    input  wire logic                       p83_irq_input_enabled,
    input  wire logic                       reload_timer_output,
    input  wire logic                       reload_timer_output_en,
    output logic                            reload_timer_input,
    output logic                            ppg_timer_trigger_in,
    output logic                            converter_trigger_in
);

    localparam int P7W = gpd_pkg::P7_W;
    localparam int P8W = gpd_pkg::P8_W;

    logic [P7W-1:0]             port_seven_data_latch;
    logic [P7W-1:0]             port_seven_direction;
    logic [P7W-1:0]             port_seven_pullup_enable;
    logic [P8W-1:0]             port_eight_data_latch;
    logic [P8W-1:0]             port_eight_direction;
    logic [P8W-1:0]             port_eight_pullup_enable;
    logic [gpd_pkg::CTRL_W-1:0] ctrl;

    logic [gpd_pkg::ADDR_W-1:0] wr_addr;
    logic [7:0]                 wr_byte;
    logic                       wr_lane;
    logic                       wr_go;
    logic                       wr_hit;

    logic [gpd_pkg::SYNC_W-1:0] pin_level;
    logic [P7W-1:0]             p7_level;
    logic [P8W-1:0]             p8_level;
    logic [P7W-1:0]             p7_gated;
    logic [P8W-1:0]             p8_gated;
    logic [P7W-1:0]             p7_periph;
    logic [P7W-1:0]             p7_rd;
    logic [P8W-1:0]             p8_rd;
    logic                       float_now;
    logic                       p83_keep;
    logic [P7W-1:0]             next_p7_out;
    logic [P7W-1:0]             next_p7_oe;
    logic [P8W-1:0]             next_p8_out;
    logic [P8W-1:0]             next_p8_oe;

    gpd_pin_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     ({alternate_trigger_pin, p8_pin_in, p7_pin_in}),
        .level   (pin_level)
    );

    assign p7_level = pin_level[gpd_pkg::SYN_P7_LSB +: P7W];
    assign p8_level = pin_level[gpd_pkg::SYN_P8_LSB +: P8W];
    assign float_now = ctrl[gpd_pkg::CTRL_PIN_FLOAT] & (stop_mode | watch_mode);
    assign p83_keep = p83_irq_input_enabled;
    assign p7_gated = float_now ? '0 : p7_level;
    always_comb begin
        p8_gated = float_now ? '0 : p8_level;
        if (float_now && p83_keep) begin
            p8_gated[gpd_pkg::PIN_TRIG_IN] = p8_level[gpd_pkg::PIN_TRIG_IN];
        end
    end

    // Only pin zero of the three-pin port carries a peripheral output.
    assign p7_periph = P7W'(reload_timer_output_en) << gpd_pkg::PIN_TMR_OUT;

    assign p7_rd = (port_seven_direction & ~p7_periph & port_seven_data_latch)
                 | (~(port_seven_direction & ~p7_periph) & p7_gated);
    assign p8_rd = (port_eight_direction & port_eight_data_latch)
                 | (~port_eight_direction & p8_gated);

    always_comb begin
        next_p7_out = port_seven_data_latch;
        next_p7_oe  = port_seven_direction;
        if (reload_timer_output_en) begin
            next_p7_out[gpd_pkg::PIN_TMR_OUT] = reload_timer_output;
            next_p7_oe[gpd_pkg::PIN_TMR_OUT]  = 1'b1;
        end
        next_p8_out = port_eight_data_latch;
        next_p8_oe  = port_eight_direction;
        if (float_now) begin
            next_p7_oe = '0;
            next_p8_oe = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p7_pin_out <= gpd_pkg::RST_P7;
            p7_pin_oe  <= gpd_pkg::RST_P7;
            p8_pin_out <= gpd_pkg::RST_P8;
            p8_pin_oe  <= gpd_pkg::RST_P8;
        end else begin
            p7_pin_out <= next_p7_out;
            p7_pin_oe  <= next_p7_oe;
            p8_pin_out <= next_p8_out;
            p8_pin_oe  <= next_p8_oe;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p7_pullup_on <= gpd_pkg::RST_P7;
            p8_pullup_on <= gpd_pkg::RST_P8;
        end else begin
            p7_pullup_on <= port_seven_pullup_enable & ~(next_p7_oe & ~next_p7_out);
            p8_pullup_on <= port_eight_pullup_enable & ~(next_p8_oe & ~next_p8_out);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_timer_input   <= 1'b0;
            ppg_timer_trigger_in <= 1'b0;
            converter_trigger_in <= 1'b0;
        end else begin
            reload_timer_input <= p7_gated[gpd_pkg::PIN_TMR_IN];
            if (ctrl[gpd_pkg::CTRL_TRIG_ALT]) begin
                ppg_timer_trigger_in <= pin_level[gpd_pkg::SYN_ALT_BIT];
                converter_trigger_in <= pin_level[gpd_pkg::SYN_ALT_BIT];
            end else begin
                ppg_timer_trigger_in <= p8_gated[gpd_pkg::PIN_TRIG_IN];
                converter_trigger_in <= p8_gated[gpd_pkg::PIN_TRIG_IN];
            end
        end
    end

    // Write address and data are taken independently; the write lands one cycle
    // after both are held, and the response follows in the same edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            wr_addr       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_addr       <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            wr_byte      <= 8'h00;
            wr_lane      <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wr_byte      <= s_axi_wdata[7:0];
            wr_lane      <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    // The map is a dense run of aligned words, so a range test replaces nine compares.
    assign wr_hit = (wr_addr <= gpd_pkg::OFS_P8_RMW) && (wr_addr[1:0] == 2'h0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= gpd_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? gpd_pkg::RESP_OKAY : gpd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // three-pin port bits two to zero
    // four-pin port bits three to zero
    // The read-modify-write alias writes the same latch as the plain data address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_seven_data_latch <= gpd_pkg::RST_P7;
            port_eight_data_latch <= gpd_pkg::RST_P8;
        end else if (wr_go && wr_lane) begin
            if (wr_addr == gpd_pkg::OFS_P7_DATA || wr_addr == gpd_pkg::OFS_P7_RMW) begin
                port_seven_data_latch <= wr_byte[P7W-1:0];
            end else if (wr_addr == gpd_pkg::OFS_P8_DATA || wr_addr == gpd_pkg::OFS_P8_RMW) begin
                port_eight_data_latch <= wr_byte[P8W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_seven_direction <= gpd_pkg::RST_P7;
            port_eight_direction <= gpd_pkg::RST_P8;
        end else if (wr_go && wr_lane) begin
            if (wr_addr == gpd_pkg::OFS_P7_DIR) begin
                port_seven_direction <= wr_byte[P7W-1:0];
            end else if (wr_addr == gpd_pkg::OFS_P8_DIR) begin
                port_eight_direction <= wr_byte[P8W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_seven_pullup_enable <= gpd_pkg::RST_P7;
            port_eight_pullup_enable <= gpd_pkg::RST_P8;
            ctrl                     <= gpd_pkg::RST_CTRL;
        end else if (wr_go && wr_lane) begin
            if (wr_addr == gpd_pkg::OFS_P7_PULL) begin
                port_seven_pullup_enable <= wr_byte[P7W-1:0];
            end else if (wr_addr == gpd_pkg::OFS_P8_PULL) begin
                port_eight_pullup_enable <= wr_byte[P8W-1:0];
            end else if (wr_addr == gpd_pkg::OFS_CTRL) begin
                ctrl <= wr_byte[gpd_pkg::CTRL_W-1:0];
            end
        end
    end

    // alias returns latch contents
    // Read data are captured at the address handshake, so a pin change after that
    // edge is not seen by the pending read.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= gpd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= gpd_pkg::RESP_OKAY;
            if (s_axi_araddr == gpd_pkg::OFS_P7_DATA) begin
                s_axi_rdata[P7W-1:0] <= p7_rd;
            end else if (s_axi_araddr == gpd_pkg::OFS_P7_DIR) begin
                s_axi_rdata[P7W-1:0] <= port_seven_direction;
            end else if (s_axi_araddr == gpd_pkg::OFS_P7_PULL) begin
                s_axi_rdata[P7W-1:0] <= port_seven_pullup_enable;
            end else if (s_axi_araddr == gpd_pkg::OFS_P8_DATA) begin
                s_axi_rdata[P8W-1:0] <= p8_rd;
            end else if (s_axi_araddr == gpd_pkg::OFS_P8_DIR) begin
                s_axi_rdata[P8W-1:0] <= port_eight_direction;
            end else if (s_axi_araddr == gpd_pkg::OFS_P8_PULL) begin
                s_axi_rdata[P8W-1:0] <= port_eight_pullup_enable;
            end else if (s_axi_araddr == gpd_pkg::OFS_CTRL) begin
                s_axi_rdata[gpd_pkg::CTRL_W-1:0] <= ctrl;
            end else if (s_axi_araddr == gpd_pkg::OFS_P7_RMW) begin
                s_axi_rdata[P7W-1:0] <= port_seven_data_latch;
            end else if (s_axi_araddr == gpd_pkg::OFS_P8_RMW) begin
                s_axi_rdata[P8W-1:0] <= port_eight_data_latch;
            end else begin
                s_axi_rresp <= gpd_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_DIR_RESET: assert property (
        !$past(aresetn) |-> (port_seven_direction == 3'h0 && port_eight_direction == 4'h0
                             && p7_pin_oe == 3'h0 && p8_pin_oe == 4'h0))
        else $error("Direction not cleared after reset.");
    AST_OUT_LATCH: assert property (
        (port_seven_direction[2] && !float_now) |=> (p7_pin_oe[2]
                                 && p7_pin_out[2] == $past(port_seven_data_latch[2])))
        else $error("Output pin does not follow its latch.");
    AST_IN_NODRIVE: assert property (
        (!port_eight_direction[0] && !float_now) |=> !p8_pin_oe[0])
        else $error("Input pin is being driven.");
    AST_FLOAT_HIZ: assert property (
        float_now |=> (p7_pin_oe == 3'h0 && p8_pin_oe == 4'h0))
        else $error("Floated pins still driven.");
    AST_PERIPH_OUT: assert property (
        (reload_timer_output_en && !float_now) |=> (p7_pin_oe[0]
                                 && p7_pin_out[0] == $past(reload_timer_output)))
        else $error("Peripheral output not routed to pin.");
    AST_PULL_LOW: assert property (
        (p7_pin_oe & ~p7_pin_out & p7_pullup_on) == 3'h0
        && (p8_pin_oe & ~p8_pin_out & p8_pullup_on) == 4'h0)
        else $error("Pull-up connected on pin driving low.");
    AST_RMW_READ: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == gpd_pkg::OFS_P8_RMW)
        |=> (s_axi_rvalid && s_axi_rdata == {28'h0000000, $past(port_eight_data_latch)}))
        else $error("Read-modify-write view does not return latch.");
    AST_FLOAT_GATE: assert property (
        float_now |=> !reload_timer_input)
        else $error("Floated input not held low.");
    AST_P83_GATE: assert property (
        (float_now && !p83_keep && !ctrl[gpd_pkg::CTRL_TRIG_ALT]) |=> !ppg_timer_trigger_in)
        else $error("Pin three trigger input not gated while floated.");
    AST_WR_RESP: assert property (
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("Write response not two cycles after handshake.");

endmodule

/* verif/dual_gpio_port_seven_eight_tb.sv */
// Self-checking bench for the dual port block.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module dual_gpio_port_seven_eight_tb;
    logic        aclk = 0, aresetn = 0, alt = 0, stp = 0, wch = 0, irq = 0, tmo = 0, tmoe = 0;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic        awr, wr, bv, arr, rv, tmi, ppg, adc;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0]  bresp, rresp;
    logic [2:0]  i7, q7, e7, u7, x7 = 0, en7 = 3'h7;
    logic [3:0]  i8, q8, e8, u8, x8 = 0, en8 = 4'hF, ws = 4'hF;
    int          miscompares = 0, total_checks = 0;
    int          m[7] = '{0, 0, 0, 0, 0, 0, 0};
    int          mk[7] = '{7, 7, 7, 15, 15, 15, 3};
    always #5 aclk = ~aclk;
    gpd_port_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .p7_pin_in(i7), .p7_pin_out(q7), .p7_pin_oe(e7),
        .p7_pullup_on(u7), .p8_pin_in(i8), .p8_pin_out(q8), .p8_pin_oe(e8), .p8_pullup_on(u8),
        .alternate_trigger_pin(alt), .stop_mode(stp), .watch_mode(wch),
        .p83_irq_input_enabled(irq), .reload_timer_output(tmo), .reload_timer_output_en(tmoe),
        .reload_timer_input(tmi), .ppg_timer_trigger_in(ppg), .converter_trigger_in(adc));
    gpd_pin_model #(.W(3)) pad7_u (.aclk(aclk), .out(q7), .oe(e7), .pull(u7), .ext_val(x7),
        .ext_en(en7), .level(i7));
    gpd_pin_model #(.W(4)) pad8_u (.aclk(aclk), .out(q8), .oe(e8), .pull(u8), .ext_val(x8),
        .ext_en(en8), .level(i8));
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad, dd, bd;
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        do begin
            @(posedge aclk);
            if (!ad && awr) begin ad = 1; awv <= 0; end
            if (!dd && wr) begin dd = 1; wv <= 0; end
            // Ready stays high afterwards, so back-to-back calls never toggle it in one step.
            if (bv) begin bd = 1; r = bresp; end
        end while (!bd);
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ad, bd;
        ara <= a;
        arv <= 1;
        rre <= 1;
        do begin
            @(posedge aclk);
            if (!ad && arr) begin ad = 1; arv <= 0; end
            if (rv) begin bd = 1; d = rd; r = rresp; end
        end while (!bd);
    endtask
    task automatic set(int i, int v);
        logic [1:0] r;
        bus_wr(8'(4 * i), 32'(v), r);
        `CHK(r, gpd_pkg::RESP_OKAY)
        m[i] = v & mk[i];
    endtask
    // Reads every view and compares it with the model; pins need time to pass the synchroniser.
    task automatic chk();
        int o7, d7, v7, v8;
        logic [31:0] d;
        logic [1:0] r;
        o7 = m[1] | int'(tmoe);
        d7 = tmoe ? ((m[0] & 6) | int'(tmo)) : m[0];
        v7 = (o7 & d7) | (~o7 & int'(x7));
        v8 = (m[4] & m[3]) | (~m[4] & int'(x8));
        repeat (6) @(posedge aclk);
        `CHK(e7, 3'(o7))
        `CHK(e8, 4'(m[4]))
        `CHK(q7 & e7, 3'(o7 & d7))
        `CHK(q8 & e8, 4'(m[4] & m[3]))
        `CHK(u7, 3'(m[2] & ~(o7 & ~d7)))
        `CHK(u8, 4'(m[5] & ~(m[4] & ~m[3])))
        `CHK(tmi, 1'(v7 >> 1))
        `CHK({ppg, adc}, {2{m[6][1] ? alt : 1'(v8 >> 3)}})
        bus_rd(gpd_pkg::OFS_P7_DATA, d, r);
        `CHK(d, 32'(v7))
        bus_rd(gpd_pkg::OFS_P8_DATA, d, r);
        `CHK(d, 32'(v8))
        bus_rd(gpd_pkg::OFS_P7_RMW, d, r);
        `CHK(d, 32'(m[0]))
        bus_rd(gpd_pkg::OFS_P8_RMW, d, r);
        `CHK(d, 32'(m[3]))
        for (int i = 1; i < 7; i++) begin
            bus_rd(8'(4 * i), d, r);
            if (i != 3) `CHK(d, 32'(m[i]))
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(32'hEA16F216));
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        chk();
        $display("test reset done");
        repeat (30) begin
            x7 <= 3'($urandom);
            x8 <= 4'($urandom);
            {alt, tmo, tmoe} <= 3'($urandom);
            for (int i = 0; i < 7; i++) set(i, $urandom);
            chk();
        end
        $display("test random done");
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        m = '{0, 0, 0, 0, 0, 0, 0};
        chk();
        $display("test midreset done");
        // peripheral output off before plain port use
        tmoe <= 0;
        for (int k = 0; k < 4; k++) begin
            set(1, 0);
            set(4, 0);
            set(6, 1);
            {wch, irq} <= 2'(k);
            stp <= !k[1];
            repeat (6) @(posedge aclk);
            `CHK({e7, e8}, 7'h00)
            bus_rd(gpd_pkg::OFS_P7_DATA, d, r);
            `CHK(d, 32'h0)
            bus_rd(gpd_pkg::OFS_P8_DATA, d, r);
            `CHK(d, 32'(irq ? x8 & 4'h8 : 4'h0))
            set(1, $urandom);
            set(4, $urandom);
            set(6, 0);
            chk();
        end
        {stp, wch} <= 2'h0;
        $display("test standby done");
        set(1, 0);
        set(4, 0);
        set(2, 7);
        set(5, 15);
        {en7, en8} <= 7'h00;
        repeat (6) @(posedge aclk);
        `CHK({u7, u8}, 7'h7F)
        bus_rd(gpd_pkg::OFS_P7_DATA, d, r);
        `CHK(d, 32'h7)
        bus_rd(gpd_pkg::OFS_P8_DATA, d, r);
        `CHK(d, 32'hF)
        {en7, en8} <= 7'h7F;
        ws <= 4'h0;
        bus_wr(gpd_pkg::OFS_P7_DIR, 32'h7, r);
        `CHK(r, gpd_pkg::RESP_OKAY)
        ws <= 4'hF;
        bus_rd(gpd_pkg::OFS_P7_DIR, d, r);
        `CHK(d, 32'h0)
        $display("test pullup done");
        bus_wr(8'h40, 32'h1, r);
        `CHK(r, gpd_pkg::RESP_SLVERR)
        bus_rd(8'h40, d, r);
        `CHK({r, d}, {gpd_pkg::RESP_SLVERR, 32'h0})
        $display("test unmapped done");
        give_verdict();
    end
    initial begin
        #500000;
        miscompares++;
        give_verdict();
    end
endmodule

/* verif/gpd_pin_model.sv */
// Pad model: resolves each pin from the block, an outside driver and the pull-up.
`timescale 1ns/1ps
module gpd_pin_model #(
    parameter int W = 3
) (
    input  wire logic         aclk,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pull,
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] level
);
    // An open pad without pull-up wanders, so a stale value can never pass for a level.
    logic [W-1:0] wander = '0;
    always_ff @(posedge aclk) begin
        wander <= ~wander;
    end
    // outside level feeds port and peripheral inputs
    always_comb begin
        for (int i = 0; i < W; i++) begin
            level[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pull[i] ? 1'b1 : wander[i];
        end
    end
endmodule
